/* hci_regs.svh */
`ifndef HCI_REGS_SVH
`define HCI_REGS_SVH

// Command opcodes: low nibble of a command byte, or the whole byte for fixed commands
`define HCI_OP_RD         4'hD
`define HCI_OP_WR         4'h5
`define HCI_OP_TXDATA     4'h4
`define HCI_CMD_FRAME_END 8'h0F
`define HCI_CMD_RXDATA    8'h0B
`define HCI_CMD_RDINT     8'h01
`define HCI_REG_ADDR_MAX  4'h3

// Control register reset values
`define HCI_CTRL0_RST 8'h03
`define HCI_CTRL1_RST 8'h00
`define HCI_CTRL2_RST 8'h63
`define HCI_CTRL3_RST 8'hFF

// Interface mode strap code
`define HCI_IFMODE_SPI 2'h2

// Status bit positions
`define HCI_ST_TX_AFULL  0
`define HCI_ST_TX_AEMPTY 1
`define HCI_ST_RX_FEND   2
`define HCI_ST_RX_AFULL  3
`define HCI_ST_RX_EMPTY  4

// FIFO thresholds, in bytes
`define HCI_TX_CAP     8'h80
`define HCI_TX_AFULL   8'h74
`define HCI_TX_AEMPTY  8'h0C
`define HCI_RX_AFULL   8'h62

// UART timing
`define HCI_CLK_HZ          50000000
`define HCI_UART_BAUD_DEF   115200
`define HCI_UART_BAUD_MAX   921200
`define HCI_UART_PERIOD_DEF (`HCI_CLK_HZ / `HCI_UART_BAUD_DEF)
`define HCI_UART_PERIOD_MIN (`HCI_CLK_HZ / `HCI_UART_BAUD_MAX)
`define HCI_UART_MEAS_TOL   2

`endif

/* hci_pkg.sv */
package hci_pkg;

  // UART receiver states
  typedef enum logic [2:0] {
    HCI_RX_IDLE  = 3'b000,
    HCI_RX_MEAS  = 3'b001,
    HCI_RX_START = 3'b010,
    HCI_RX_DATA  = 3'b011,
    HCI_RX_STOP  = 3'b100
  } hci_rx_state_type;

  // What the bytes after an SPI command mean
  typedef enum logic [1:0] {
    HCI_SPI_NONE = 2'b00,
    HCI_SPI_TX   = 2'b01,
    HCI_SPI_RX   = 2'b10
  } hci_spi_mode_type;

  // System clock state
  typedef struct packed {
    logic [1:0]       mode_cnt;
    logic             mode_spi;
    logic [1:0]       ifm_s1;
    logic [1:0]       ifm_s2;
    logic             din_s1;
    logic             din_s2;
    logic             din_s3;
    logic             dc_s1;
    logic             dc_s2;
    logic             tog_s1;
    logic             tog_s2;
    logic             tog_s3;
    logic [1:0]       cp_s1;
    logic [1:0]       cp_s2;
    logic [1:0]       cp_s3;
    logic [9:0]       period;
    hci_rx_state_type rx_st;
    logic [9:0]       rx_cnt;
    logic [2:0]       rx_bit;
    logic [7:0]       rx_sh;
    logic             tx_busy;
    logic [9:0]       tx_sh;
    logic [9:0]       tx_cnt;
    logic [3:0]       tx_bit;
    logic             uart_txd;
    logic             uresp_pend;
    logic [3:0][7:0]  ctrl;
    logic [1:0]       codec;
    logic             rfe;
    logic             wr_pend;
    logic [1:0]       wr_addr;
    hci_spi_mode_type smode;
    logic             sfirst;
    logic [7:0]       resp;
    logic [7:0]       txd;
    logic             tx_push;
    logic             tx_fe;
    logic             rx_pop;
    logic             irq;
  } hci_sys_type;

  // Serial clock rising edge state
  typedef struct packed {
    logic [2:0] bitcnt;
    logic [7:0] sh;
    logic [7:0] hold;
    logic       tog;
  } hci_rise_type;

  // Serial clock falling edge state
  typedef struct packed {
    logic [7:0] sh;
    logic       miso;
  } hci_fall_type;

endpackage

/* hci_host_command_interface.sv */
// How it works
// - Read command: address high, 0xD low
// - Write command, then one value byte stored
// - Read returns register contents on data out
// - UART starts at default bit rate
// - Command mode blocks data both ways
// - Command byte start bit measures host rate
// - In UART mode, last change of pins or register wins
// - SPI samples rising, drives falling, idle high
// - Transmit command picks the codec
// - Frame-end command queues frame-end indication
// - Receive command streams receive FIFO bytes
// - SPI register access uses same opcodes
// - Read-interrupt command returns status register
// - In SPI mode, interrupt is status masked by control 3
// - Status 0: transmit FIFO at 116
// - Status 1: transmit FIFO down to 12
// - Status 2: powerline frame end received
// - Status 3: receive FIFO at 98
// - Status 4: receive FIFO empty
// - Mode pins sampled after reset, held
`include "hci_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module hci_host_command_interface
  import hci_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [1:0] if_mode,
  input  wire logic       host_data_in,
  input  wire logic       cmd_select,
  input  wire logic       spi_sck,
  input  wire logic [1:0] codec_sel_pin,
  input  wire logic [7:0] tx_count,
  input  wire logic [7:0] rx_count,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_frame_end,
  output logic            host_data_out,
  output logic            host_irq,
  output logic [1:0]      codec_sel,
  output logic            proto_spi,
  output logic [7:0]      tx_data,
  output logic            tx_push,
  output logic            tx_frame_end,
  output logic            rx_pop
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  hci_sys_type  s_r;          // System clock state
  hci_sys_type  s_nxt;        // Its next value
  hci_rise_type r_r;          // Serial clock rising edge state
  hci_rise_type r_nxt;        // Its next value
  hci_fall_type f_r;          // Serial clock falling edge state
  hci_fall_type f_nxt;        // Its next value
  logic         spi_arst_n;   // Serial logic reset: device reset or deselect
  logic [7:0]   status;       // Live interrupt status
  logic         byte_ev;      // A host byte completed this cycle
  logic [7:0]   byte_val;     // That byte
  logic         byte_cmd;     // That byte is a command
  logic         rd_int;       // Status register read this cycle

  // Status bits from FIFO levels and the sticky frame-end flag
  function automatic logic [7:0] hci_status(input logic [7:0] txc, input logic [7:0] rxc,
                                            input logic fend);
    logic [7:0] st;
    st                       = 8'h00;
    st[`HCI_ST_TX_AFULL]     = (txc >= `HCI_TX_AFULL);
    st[`HCI_ST_TX_AEMPTY]    = (txc <= `HCI_TX_AEMPTY);
    st[`HCI_ST_RX_FEND]      = fend;
    st[`HCI_ST_RX_AFULL]     = (rxc >= `HCI_RX_AFULL);
    st[`HCI_ST_RX_EMPTY]     = (rxc == 8'h00);
    return st;
  endfunction

  // Register address is valid only in the range 0 to 3
  function automatic logic hci_addr_ok(input logic [3:0] a);
    return (a <= `HCI_REG_ADDR_MAX);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock domain

  // Deselect clears the bit position, so every frame starts byte aligned
  assign spi_arst_n = rstn & ~cmd_select;

  // Rising edge: shift in, MSB first, and hand over each byte by toggle
  always_comb begin
    r_nxt        = r_r;
    r_nxt.sh     = {r_r.sh[6:0], host_data_in};
    r_nxt.bitcnt = 3'(r_r.bitcnt + 3'h1);
    if (r_r.bitcnt == 3'h7) begin
      r_nxt.hold = {r_r.sh[6:0], host_data_in};
      r_nxt.tog  = ~r_r.tog;
    end
  end

  // Rising edge register
  always_ff @(posedge spi_sck or negedge spi_arst_n) begin
    if (!spi_arst_n) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  // Falling edge: load the answer at each byte boundary, then shift out
  always_comb begin
    f_nxt = f_r;
    if (r_r.bitcnt == 3'h0) begin
      // Answer word is quasi static: it settles well before this edge
      f_nxt.miso = s_r.resp[7];
      f_nxt.sh   = {s_r.resp[6:0], 1'b0};
    end else begin
      f_nxt.miso = f_r.sh[7];
      f_nxt.sh   = {f_r.sh[6:0], 1'b0};
    end
  end

  // Falling edge register
  always_ff @(negedge spi_sck or negedge spi_arst_n) begin
    if (!spi_arst_n) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System clock domain

  // Synchronisers, UART engine, command decode and status
  always_comb begin
    s_nxt         = s_r;
    byte_ev       = 1'b0;
    byte_val      = 8'h00;
    byte_cmd      = 1'b0;
    rd_int        = 1'b0;
    s_nxt.tx_push = 1'b0;
    s_nxt.tx_fe   = 1'b0;
    s_nxt.rx_pop  = 1'b0;
    status        = hci_status(tx_count, rx_count, s_r.rfe);

    // Two-flop chains for strap and select, three-flop for data, toggle and codec pins; only stage two and later are looked at
    s_nxt.ifm_s1 = if_mode;
    s_nxt.ifm_s2 = s_r.ifm_s1;
    s_nxt.din_s1 = host_data_in;
    s_nxt.din_s2 = s_r.din_s1;
    s_nxt.din_s3 = s_r.din_s2;
    s_nxt.dc_s1  = cmd_select;
    s_nxt.dc_s2  = s_r.dc_s1;
    s_nxt.tog_s1 = r_r.tog;
    s_nxt.tog_s2 = s_r.tog_s1;
    s_nxt.tog_s3 = s_r.tog_s2;
    s_nxt.cp_s1  = codec_sel_pin;
    s_nxt.cp_s2  = s_r.cp_s1;
    s_nxt.cp_s3  = s_r.cp_s2;

    // Strap is caught once the chain is full, then frozen until reset
    if (s_r.mode_cnt != 2'h3) begin
      s_nxt.mode_cnt = 2'(s_r.mode_cnt + 2'h1);
      if (s_r.mode_cnt == 2'h2) begin
        s_nxt.mode_spi = (s_r.ifm_s2 == `HCI_IFMODE_SPI);
      end
    end

    // UART receiver; reserved straps fall back to UART
    case (s_r.rx_st)
      HCI_RX_IDLE: begin
        if (!s_r.mode_spi && (s_r.mode_cnt == 2'h3) && s_r.din_s3 && !s_r.din_s2) begin
          if (!s_r.dc_s2) begin
            // Read and write opcodes have bit 0 set, so the low pulse is the start bit alone
            s_nxt.rx_st  = HCI_RX_MEAS;
            s_nxt.rx_cnt = 10'h001;
          end else begin
            s_nxt.rx_st  = HCI_RX_START;
            s_nxt.rx_cnt = {1'b0, s_r.period[9:1]};
          end
        end
      end
      HCI_RX_MEAS: begin
        if (s_r.din_s2) begin
          // Accept only widths near or below the top supported rate
          if (s_r.rx_cnt >= 10'(`HCI_UART_PERIOD_MIN - `HCI_UART_MEAS_TOL)) begin
            s_nxt.period = s_r.rx_cnt;
            s_nxt.rx_cnt = {1'b0, s_r.rx_cnt[9:1]};
            s_nxt.rx_bit = 3'h0;
            s_nxt.rx_st  = HCI_RX_DATA;
          end else begin
            s_nxt.rx_st = HCI_RX_IDLE;
          end
        end else if (s_r.rx_cnt == 10'h3FF) begin
          s_nxt.rx_st = HCI_RX_IDLE;                         // Too slow: line stuck low
        end else begin
          s_nxt.rx_cnt = 10'(s_r.rx_cnt + 10'h001);
        end
      end
      HCI_RX_START: begin
        if (s_r.rx_cnt != 10'h000) begin
          s_nxt.rx_cnt = 10'(s_r.rx_cnt - 10'h001);
        end else if (!s_r.din_s2) begin
          s_nxt.rx_cnt = 10'(s_r.period - 10'h001);
          s_nxt.rx_bit = 3'h0;
          s_nxt.rx_st  = HCI_RX_DATA;
        end else begin
          s_nxt.rx_st = HCI_RX_IDLE;                         // Glitch, not a start bit
        end
      end
      HCI_RX_DATA: begin
        if (s_r.rx_cnt != 10'h000) begin
          s_nxt.rx_cnt = 10'(s_r.rx_cnt - 10'h001);
        end else begin
          s_nxt.rx_sh  = {s_r.din_s2, s_r.rx_sh[7:1]};
          s_nxt.rx_cnt = 10'(s_r.period - 10'h001);
          s_nxt.rx_bit = 3'(s_r.rx_bit + 3'h1);
          if (s_r.rx_bit == 3'h7) begin
            s_nxt.rx_st = HCI_RX_STOP;
          end
        end
      end
      HCI_RX_STOP: begin
        if (s_r.rx_cnt != 10'h000) begin
          s_nxt.rx_cnt = 10'(s_r.rx_cnt - 10'h001);
        end else begin
          // Stop bit is not checked; a framing error still yields the byte
          byte_ev     = 1'b1;
          byte_val    = s_r.rx_sh;
          byte_cmd    = ~s_r.dc_s2;
          s_nxt.rx_st = HCI_RX_IDLE;
        end
      end
      default: begin
        s_nxt.rx_st = HCI_RX_IDLE;
      end
    endcase

    // SPI byte arrives from the serial domain; first byte of a selection is the command.
    // Deselect also clears the toggle, so a toggle seen while deselected is no byte.
    if (s_r.mode_spi && !s_r.dc_s2 && (s_r.tog_s2 != s_r.tog_s3)) begin
      byte_ev      = 1'b1;
      byte_val     = r_r.hold;
      byte_cmd     = s_r.sfirst;
      s_nxt.sfirst = 1'b0;
    end
    if (s_r.mode_spi && s_r.dc_s2) begin
      s_nxt.sfirst  = 1'b1;
      s_nxt.smode   = HCI_SPI_NONE;
      s_nxt.wr_pend = 1'b0;
    end

    // Codec pins change the codec in UART mode
    if (!s_r.mode_spi && (s_r.cp_s2 != s_r.cp_s3)) begin
      s_nxt.codec = s_r.cp_s2;
    end

    // Byte handling: pending write value first, then commands, then data
    if (byte_ev) begin
      if (s_r.wr_pend) begin
        s_nxt.wr_pend             = 1'b0;
        s_nxt.ctrl[s_r.wr_addr]   = byte_val;
        if (s_r.wr_addr == 2'h2) begin
          s_nxt.codec = byte_val[1:0];
        end
      end else if (byte_cmd) begin
        if ((byte_val[3:0] == `HCI_OP_RD) && hci_addr_ok(byte_val[7:4])) begin
          s_nxt.resp       = s_r.ctrl[byte_val[5:4]];
          s_nxt.uresp_pend = ~s_r.mode_spi;
        end else if ((byte_val[3:0] == `HCI_OP_WR) && hci_addr_ok(byte_val[7:4])) begin
          s_nxt.wr_pend = 1'b1;
          s_nxt.wr_addr = byte_val[5:4];
        end else if (s_r.mode_spi) begin
          if ((byte_val[3:0] == `HCI_OP_TXDATA) && hci_addr_ok(byte_val[7:4])) begin
            s_nxt.smode = HCI_SPI_TX;
            s_nxt.codec = ~byte_val[5:4];
          end else if (byte_val == `HCI_CMD_FRAME_END) begin
            s_nxt.tx_fe = 1'b1;
          end else if (byte_val == `HCI_CMD_RXDATA) begin
            s_nxt.smode  = HCI_SPI_RX;
            s_nxt.resp   = rx_data;
            s_nxt.rx_pop = (rx_count != 8'h00);
          end else if (byte_val == `HCI_CMD_RDINT) begin
            s_nxt.resp = status;
            rd_int     = 1'b1;
          end
        end
      end else if (s_r.mode_spi) begin
        if (s_r.smode == HCI_SPI_TX) begin
          s_nxt.txd     = byte_val;
          s_nxt.tx_push = (tx_count < `HCI_TX_CAP);
        end else if (s_r.smode == HCI_SPI_RX) begin
          // Empty FIFO: the byte handed out is undefined and nothing pops
          s_nxt.resp   = rx_data;
          s_nxt.rx_pop = (rx_count != 8'h00);
        end
      end else begin
        // UART data byte heads for the powerline
        s_nxt.txd     = byte_val;
        s_nxt.tx_push = (tx_count < `HCI_TX_CAP);
      end
    end

    // Frame-end flag: a new indication beats a clearing read
    s_nxt.rfe = rx_frame_end | (s_r.rfe & ~rd_int);

    // UART transmitter: a register answer first, else forwarded powerline data
    if (s_r.tx_busy) begin
      if (s_r.tx_cnt != 10'h000) begin
        s_nxt.tx_cnt = 10'(s_r.tx_cnt - 10'h001);
      end else if (s_r.tx_bit == 4'h9) begin
        s_nxt.tx_busy  = 1'b0;
        s_nxt.uart_txd = 1'b1;
      end else begin
        s_nxt.tx_sh    = {1'b1, s_r.tx_sh[9:1]};
        s_nxt.uart_txd = s_r.tx_sh[1];
        s_nxt.tx_bit   = 4'(s_r.tx_bit + 4'h1);
        s_nxt.tx_cnt   = 10'(s_r.period - 10'h001);
      end
    end else if (s_r.uresp_pend) begin
      s_nxt.uresp_pend = 1'b0;
      s_nxt.tx_busy    = 1'b1;
      s_nxt.tx_sh      = {1'b1, s_r.resp, 1'b0};
      s_nxt.uart_txd   = 1'b0;
      s_nxt.tx_bit     = 4'h0;
      s_nxt.tx_cnt     = 10'(s_r.period - 10'h001);
    end else if (!s_r.mode_spi && s_r.dc_s2 && (rx_count != 8'h00) && !s_r.rx_pop) begin
      // Command mode holds powerline bytes back in the FIFO
      s_nxt.rx_pop   = 1'b1;
      s_nxt.tx_busy  = 1'b1;
      s_nxt.tx_sh    = {1'b1, rx_data, 1'b0};
      s_nxt.uart_txd = 1'b0;
      s_nxt.tx_bit   = 4'h0;
      s_nxt.tx_cnt   = 10'(s_r.period - 10'h001);
    end

    // Shared pin: masked interrupt in SPI mode, ready to receive in UART mode
    if (s_r.mode_spi) begin
      s_nxt.irq = |(status & s_r.ctrl[3]);
    end else begin
      s_nxt.irq = ~status[`HCI_ST_TX_AFULL];
    end
  end

  // System register; data mode in UART blocks nothing, command mode gates above
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r          <= '0;
      s_r.din_s1   <= 1'b1;
      s_r.din_s2   <= 1'b1;
      s_r.din_s3   <= 1'b1;
      s_r.dc_s1    <= 1'b1;
      s_r.dc_s2    <= 1'b1;
      s_r.period   <= 10'(`HCI_UART_PERIOD_DEF);
      s_r.uart_txd <= 1'b1;
      s_r.ctrl[0]  <= `HCI_CTRL0_RST;
      s_r.ctrl[1]  <= `HCI_CTRL1_RST;
      s_r.ctrl[2]  <= `HCI_CTRL2_RST;
      s_r.ctrl[3]  <= `HCI_CTRL3_RST;
      s_r.codec    <= 2'h3;
      s_r.sfirst   <= 1'b1;
      s_r.rx_st    <= HCI_RX_IDLE;
      s_r.smode    <= HCI_SPI_NONE;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // One pin serves two domains; the strap picks which flop drives it
  assign host_data_out = s_r.mode_spi ? f_r.miso : s_r.uart_txd;
  assign host_irq      = s_r.irq;
  assign codec_sel     = s_r.codec;
  assign proto_spi     = s_r.mode_spi;
  assign tx_data       = s_r.txd;
  assign tx_push       = s_r.tx_push;
  assign tx_frame_end  = s_r.tx_fe;
  assign rx_pop        = s_r.rx_pop;

endmodule // hci_host_command_interface

`default_nettype wire

/* hci_host_properties.sv */
`timescale 1ns/1ps
`default_nettype none

module hci_host_properties
  import hci_pkg::*;
(
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic [1:0] if_mode,
  input wire logic       cmd_select,
  input wire logic       spi_sck,
  input wire logic [7:0] tx_count,
  input wire logic       host_data_out,
  input wire logic       host_irq,
  input wire logic [1:0] codec_sel,
  input wire logic       proto_spi,
  input wire logic       tx_push,
  input wire logic       tx_frame_end,
  input wire logic       rx_pop
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////
  logic [2:0] rel_cnt_r;  // Edges since reset release, saturating
  // Strap must be settled by the time this saturates
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rel_cnt_r <= 3'h0;
    end else if (rel_cnt_r != 3'h7) begin
      rel_cnt_r <= rel_cnt_r + 3'h1;
    end
  end
  // Long enough to cover the input sync stages
  sequence cmd_hold;
    (!proto_spi && !cmd_select)[*8];
  endsequence
  // UART strap held, reset well past
  sequence uart_steady;
    !proto_spi && $past(!proto_spi) && $past(rstn, 2);
  endsequence
  ////////////////////////////////////////////////////////////
  a_cmd_no_push: assert property (cmd_hold |=> !tx_push)
    else $error("byte pushed in command mode");
  a_irq_ready: assert property (uart_steady |-> host_irq == ($past(tx_count) < 8'h74))
    else $error("ready flag wrong for fill level");
  a_push_not_full: assert property (tx_push |-> $past(tx_count) < 8'h80)
    else $error("push into full transmit fifo");
  a_fend_pulse: assert property (tx_frame_end |-> proto_spi ##1 !tx_frame_end)
    else $error("frame end pulse wrong");
  a_pop_pulse: assert property (rx_pop |=> !rx_pop)
    else $error("pop longer than one cycle");
  a_mode_hold: assert property (rel_cnt_r == 3'h7 |-> proto_spi == (if_mode == 2'h2) && $stable(proto_spi))
    else $error("protocol choice wrong or moved");
  a_codec_reset: assert property ($rose(rstn) |-> codec_sel == 2'h3 && host_data_out && !tx_push)
    else $error("reset state wrong");
  a_miso_fall: assert property (proto_spi && !cmd_select && $past(!cmd_select) && $changed(host_data_out)
    |-> !spi_sck)
    else $error("data out moved while serial clock high");
endmodule // hci_host_properties

bind hci_host_command_interface hci_host_properties u_props (
  .clk(clk), .rstn(rstn), .if_mode(if_mode), .cmd_select(cmd_select), .spi_sck(spi_sck),
  .tx_count(tx_count), .host_data_out(host_data_out), .host_irq(host_irq), .codec_sel(codec_sel),
  .proto_spi(proto_spi), .tx_push(tx_push), .tx_frame_end(tx_frame_end), .rx_pop(rx_pop));

`default_nettype wire

/* hci_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Behavioural host: UART port and SPI master
module hci_host_model
  import hci_pkg::*;
(
  input  wire logic host_data_out,
  output var logic  host_data_in,
  output var logic  cmd_select,
  output var logic  spi_sck
);
  initial begin
    host_data_in = 1'b1;  // UART line idles high
    cmd_select   = 1'b1;  // Data mode, chip not selected
    spi_sck      = 1'b1;  // Stands high outside frames
  end
  // Low selects command mode, or the chip in SPI mode
  task automatic sel(input logic v);
    cmd_select = v;
    #100;
  endtask
  // One 8N1 character, LSB first
  task automatic uart_tx(input logic [7:0] b, input int bit_ns);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      host_data_in = f[i];
      #(bit_ns);
    end
  endtask
  // Bounded wait for a start bit, then sample each bit centre
  task automatic uart_rx(input int bit_ns, output logic [7:0] b);
    b = 8'hXX;
    for (int n = 0; n < 12 * bit_ns / 5 && host_data_out !== 1'b0; n++) #5;
    #(bit_ns * 3 / 2);
    for (int i = 0; i < 8; i++) begin
      b[i] = host_data_out;
      #(bit_ns);
    end
  endtask
  // Answer can start before our stop bit ends, so listen meanwhile
  task automatic uart_read(input logic [7:0] c, input int bit_ns, output logic [7:0] b);
    fork
      uart_tx(c, bit_ns);
      uart_rx(bit_ns, b);
    join
  endtask
  // MSB first at 8 MHz; shift on fall, device samples on rise
  task automatic spi_xfer(input logic [7:0] o, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      spi_sck = 1'b0;
      host_data_in = o[i];
      #62.5;
      spi_sck = 1'b1;
      r[i] = host_data_out;
      #62.5;
    end
    #250;  // Gives the answer time to cross clock domains
  endtask
  // Deselect; released data line must not keep its last level
  task automatic spi_end();
    cmd_select = 1'b1;
    host_data_in = ~host_data_in;
    #300;
  endtask
  // Command byte and a second byte in one selection; any answer rides the second
  task automatic spi_pair(input logic [7:0] c, input logic [7:0] v, output logic [7:0] r);
    sel(1'b0);
    spi_xfer(c, r);
    spi_xfer(v, r);
    spi_end();
  endtask
  // Command byte, then one byte to collect the answer
  task automatic spi_cmd(input logic [7:0] c, output logic [7:0] r);
    spi_pair(c, 8'h00, r);
  endtask
endmodule // hci_host_model

`default_nettype wire

/* hci_host_command_interface_test.sv */
`timescale 1ns/1ps
`default_nettype none

module hci_host_command_interface_test
  import hci_pkg::*;
  ;
  localparam int BIT_DEF  = 8680;  // 434 clk per bit, default rate
  localparam int BIT_FAST = 4340;  // 217 clk per bit, host at 230.4 kbit/s
  logic       clk, rstn, rx_frame_end;
  logic [1:0] if_mode, codec_sel_pin;
  logic [7:0] tx_count, rx_count, rx_data;
  logic       host_data_in, cmd_select, spi_sck, host_data_out, host_irq, proto_spi;
  logic       tx_push, tx_frame_end, rx_pop;
  logic [1:0] codec_sel;
  logic [7:0] tx_data, last_push, got;
  int         fails = 0, num_checks = 0, cycles = 0, push_cnt = 0, fe_cnt = 0, pop_cnt = 0;

  hci_host_command_interface DUT (
    .clk(clk), .rstn(rstn), .if_mode(if_mode), .host_data_in(host_data_in), .cmd_select(cmd_select),
    .spi_sck(spi_sck), .codec_sel_pin(codec_sel_pin), .tx_count(tx_count), .rx_count(rx_count),
    .rx_data(rx_data), .rx_frame_end(rx_frame_end), .host_data_out(host_data_out), .host_irq(host_irq),
    .codec_sel(codec_sel), .proto_spi(proto_spi), .tx_data(tx_data), .tx_push(tx_push),
    .tx_frame_end(tx_frame_end), .rx_pop(rx_pop));
  hci_host_model host (.host_data_out(host_data_out), .host_data_in(host_data_in),
    .cmd_select(cmd_select), .spi_sck(spi_sck));
  ////////////////////////////////////////////////////////////
  always #10 clk = ~clk;
  // Pulse counters, plus the hang limit
  always @(posedge clk) begin
    cycles++;
    if (tx_push === 1'b1) begin
      push_cnt++;
      last_push = tx_data;
    end
    if (tx_frame_end === 1'b1) fe_cnt++;
    if (rx_pop === 1'b1) pop_cnt++;
    // Stand-in receive FIFO head, moves on at each pop
    rx_data <= !rstn ? 8'hB7 : (rx_pop === 1'b1) ? 8'(rx_data + 8'h11) : rx_data;
    if (cycles == 90000) begin
      fails++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] act);
    num_checks++;
    if (act !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, act);
    end
  endtask
  // Bounded waits on crossings and sync stages
  task automatic settle(ref int c, input int e);
    for (int i = 0; i < 60 && c != e; i++) @(posedge clk) #1;
  endtask
  task automatic chk_irq(input logic e);
    for (int i = 0; i < 20 && host_irq !== e; i++) @(posedge clk) #1;
    chk("irq", {7'h00, e}, {7'h00, host_irq});
  endtask
  task automatic chk_codec(input logic [1:0] e);
    for (int i = 0; i < 20 && codec_sel !== e; i++) @(posedge clk) #1;
    chk("codec", {6'h00, e}, {6'h00, codec_sel});
  endtask
  task automatic do_reset(input logic [1:0] m);
    @(posedge clk) #1;
    rstn = 1'b0;
    if_mode = m;
    repeat (8) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Data byte at default rate, ready flag at its threshold
  task automatic t_uart_data();
    host.uart_tx(8'hA6, BIT_DEF);
    settle(push_cnt, 1);
    chk("uart push", 8'hA6, last_push);
    tx_count = 8'h74;
    chk_irq(1'b0);
    tx_count = 8'h73;
    chk_irq(1'b1);
    $display("uart data done");
  endtask
  // Register write and read, then a read that retunes the rate
  task automatic t_uart_cmd();
    host.sel(1'b0);
    host.uart_tx(8'h35, BIT_DEF);
    host.uart_tx(8'hC3, BIT_DEF);
    host.uart_read(8'h3D, BIT_DEF, got);
    chk("uart ctrl3", 8'hC3, got);
    host.uart_read(8'h2D, BIT_FAST, got);
    chk("ctrl2 at new rate", 8'h63, got);
    chk("cmd mode pushes", 8'h01, 8'(push_cnt));
    rx_count = 8'h01;
    repeat (50) @(posedge clk) #1;
    chk("cmd mode pops", 8'h00, 8'(pop_cnt));
    host.sel(1'b1);
    host.uart_rx(BIT_FAST, got);
    rx_count = 8'h00;
    chk("forwarded", 8'hB7, got);
    host.uart_tx(8'h3C, BIT_FAST);
    settle(push_cnt, 2);
    chk("fast push", 8'h3C, last_push);
    $display("uart command done");
  endtask
  // Pins and control register 2 both steer the codec
  task automatic t_codec();
    codec_sel_pin = 2'h1;
    chk_codec(2'h1);
    host.sel(1'b0);
    host.uart_tx(8'h25, BIT_FAST);
    host.sel(1'b1);
    host.uart_tx(8'h62, BIT_FAST);
    chk_codec(2'h2);
    chk("value not pushed", 8'h02, 8'(push_cnt));
    codec_sel_pin = 2'h0;
    chk_codec(2'h0);
    $display("codec done");
  endtask
  // Every transmit code, then a frame end on a fresh select
  task automatic t_spi_tx();
    for (int i = 0; i < 4; i++) begin
      host.spi_pair(8'(16 * i + 4), 8'(8'h90 + i), got);
      settle(push_cnt, i + 1);
      chk("spi payload", 8'(8'h90 + i), last_push);
      chk_codec(2'(3 - i));
    end
    host.sel(1'b0);
    host.spi_xfer(8'h0F, got);
    host.spi_end();
    settle(fe_cnt, 1);
    chk("frame ends", 8'h01, 8'(fe_cnt));
    $display("spi transmit done");
  endtask
  // Mask register, status bits, interrupt and receive stream
  task automatic t_spi_status();
    host.spi_pair(8'h35, 8'h0D, got);
    host.spi_cmd(8'h3D, got);
    chk("spi ctrl3", 8'h0D, got);
    chk_irq(1'b0);
    @(posedge clk) #1 rx_frame_end = 1'b1;
    @(posedge clk) #1 rx_frame_end = 1'b0;
    chk_irq(1'b1);
    host.spi_cmd(8'h01, got);
    chk("status empty", 8'h16, got);
    tx_count = 8'h74;
    rx_count = 8'h62;
    host.spi_cmd(8'h01, got);
    chk("status full", 8'h09, got);
    chk_irq(1'b1);
    host.spi_pair(8'h35, 8'h06, got);
    chk_irq(1'b0);
    host.spi_cmd(8'h0B, got);
    // One pop forwarded in UART mode, one at the command, one per byte after it
    settle(pop_cnt, 3);
    chk("rx byte", 8'hB7, got);
    chk("pops", 8'h03, 8'(pop_cnt));
    $display("spi status done");
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    clk           = 1'b0;
    rstn          = 1'b0;
    codec_sel_pin = 2'h3;   // Same as reset codec
    tx_count      = 8'h05;
    rx_count      = 8'h00;  // Empty until the forwarding check
    rx_frame_end  = 1'b0;
    do_reset(2'h0);
    t_uart_data();
    t_uart_cmd();
    t_codec();
    tx_count = 8'h05;
    do_reset(2'h2);
    t_spi_tx();
    t_spi_status();
    close_out();
  end
endmodule // hci_host_command_interface_test

`default_nettype wire
